/* File: dv/bert_line_model.sv */
// bert_line_model: serial line looped from the tester's transmit pin to its receive pin.
// Assumes: the bench holds run high while traffic flows; clk is the tester's clock.
`timescale 1ns/1ps
`default_nettype none
module bert_line_model (
  // control
  input wire logic clk,
  input wire logic run,
  // tester side
  input wire logic tx_data,
  input wire logic tx_data_oe,
  output logic bit_clock,
  output logic rx_clock,
  output logic rx_data
);
  logic last_r = 1'b0;
  initial bit_clock = 1'b0;
  // 800 ns bit period, parked low between frames
  always begin
    #400;
    bit_clock = run ? ~bit_clock : 1'b0;
  end
  // receive clock is the transmit clock, looped straight back to the receive pin
  assign rx_clock = bit_clock;
  always @(posedge clk) begin
    if (tx_data_oe) begin
      last_r <= tx_data;
    end
  end
  // a released line must not hold its last level
  assign rx_data = tx_data_oe ? tx_data : ~last_r;
endmodule
`default_nettype wire

/* File: dv/tb.sv */
// tb: self-checking bench for bert_top with the line looped back.
// Assumes: bert_pkg compiled first and bert_params.svh on the include path.
`include "bert_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
  import bert_pkg::*;
  logic clk, rst_n, ld_pin, lc_pin, test_mode, run;
  bert_req_t bus_req;
  logic [7:0] bus_rdata;
  logic bus_rdata_oe, tx_clk, rx_clk, rx_dat, tx_data, tx_data_oe;
  logic sync_loss, sync_loss_oe, int_n_out, int_n_oe;
  int n_mismatch, comparisons;
  // ****************************************
  // instances
  // ****************************************
  bert_top dut (.clk(clk), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .bus_rdata_oe(bus_rdata_oe), .transmit_bit_clock(tx_clk), .rx_clock(rx_clk),
    .rx_data(rx_dat), .transmit_load_strobe(ld_pin), .count_latch(lc_pin),
    .bus_style_strap(1'b1), .test_mode(test_mode), .tx_data(tx_data),
    .tx_data_oe(tx_data_oe), .receive_sync_loss_out(sync_loss), .sync_loss_oe(sync_loss_oe),
    .int_n_out(int_n_out), .int_n_oe(int_n_oe));
  bert_line_model line (.clk(clk), .run(run), .tx_data(tx_data), .tx_data_oe(tx_data_oe),
    .bit_clock(tx_clk), .rx_clock(rx_clk), .rx_data(rx_dat));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic end_sim();
    $display("counts: %0d mismatches in %0d comparisons", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    bus_req <= '0;
  endtask
  // data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    bus_req <= '0;
    #1;
    d = bus_rdata;
  endtask
  task automatic rd32(input logic [7:0] a, output logic [31:0] v);
    logic [7:0] b;
    for (int i = 0; i < 4; i++) begin
      rd(8'(a + i), b);
      v[8*i +: 8] = b;
    end
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs();
    logic [7:0] d;
    rd(`BERT_A_LEN, d);
    chk("read enable", 32'(bus_rdata_oe), 32'h1);
    chk("length reset", 32'(d), 32'h1F);
    rd(`BERT_A_TAP, d);
    chk("tap reset", 32'(d), 32'h00);
    rd(8'h20, d);
    chk("unmapped read", 32'(d), 32'h00);
    wr(`BERT_A_TAP, 8'h0D);
    rd(`BERT_A_TAP, d);
    chk("tap readback", 32'(d), 32'h0D);
    for (int i = 0; i < 4; i++) wr(8'(`BERT_A_SEED0 + i), 8'h00);
    wr(`BERT_A_INJ, 8'h00);
    wr(`BERT_A_MASK, 8'h00);
    rd(`BERT_A_STAT, d);
    chk("strap in status", 32'(d & 8'h09), 32'h08);
    $display("test regs done");
  endtask
  // load an 8-bit repetitive pattern by pin or by control bit 7
  task automatic t_load(input logic via_reg, input logic [7:0] seed);
    logic [7:0] got;
    wr(`BERT_A_SEED0, seed);
    wr(`BERT_A_LEN, 8'h07);
    wr(`BERT_A_CTRL, 8'h01);
    @(negedge tx_clk);
    if (via_reg) begin
      wr(`BERT_A_CTRL, 8'h81);
    end else begin
      @(posedge clk);
      ld_pin <= 1'b1;
    end
    repeat (3) @(posedge tx_clk);
    for (int i = 0; i < 8; i++) begin
      @(posedge tx_clk);
      got[7-i] = tx_data;
    end
    chk("pattern msb first", 32'(got), 32'(seed));
    @(posedge clk);
    ld_pin <= 1'b0;
    wr(`BERT_A_CTRL, 8'h01);
    $display("test load done");
  endtask
  // a constant repetitive pattern must show in the all-ones or all-zeros flag
  task automatic t_flags(input logic [7:0] seed, input logic [7:0] flags);
    logic [7:0] d;
    wr(`BERT_A_SEED0, seed);
    wr(`BERT_A_CTRL, 8'h01);
    @(negedge tx_clk);
    wr(`BERT_A_CTRL, 8'h81);
    repeat (40) @(posedge tx_clk);
    rd(`BERT_A_STAT, d);
    chk("pattern flags", 32'(d & 8'h06), 32'(flags));
    wr(`BERT_A_CTRL, 8'h01);
    $display("test flags done");
  endtask
  // pseudorandom x^7 + x^6 + 1: length 7, second tap at stage 5
  task automatic t_prbs();
    logic [7:0] d;
    logic [31:0] v;
    d = 8'h00;
    wr(`BERT_A_SEED0, 8'h5B);
    wr(`BERT_A_LEN, 8'h06);
    wr(`BERT_A_TAP, 8'h05);
    wr(`BERT_A_CTRL, 8'h02);
    wr(`BERT_A_CTRL, 8'h82);
    for (int i = 0; i < 200 && d[0] !== 1'b1; i++) begin
      repeat (8) @(posedge clk);
      rd(`BERT_A_STAT, d);
    end
    chk("pseudorandom lock", 32'(d & 8'h07), 32'h01);
    wr(`BERT_A_CTRL, 8'h8A);
    wr(`BERT_A_INJ, 8'h08);
    repeat (30) @(posedge tx_clk);
    wr(`BERT_A_CTRL, 8'h8A);
    rd32(`BERT_A_ERR0, v);
    chk("pseudorandom single error", v, 32'h1);
    wr(`BERT_A_CTRL, 8'h02);
    $display("test prbs done");
  endtask
  task automatic t_sync();
    logic [7:0] d;
    logic [31:0] v;
    logic ok;
    d = 8'h00;
    ok = 1'b0;
    wr(`BERT_A_CTRL, 8'h03);
    for (int i = 0; i < 200 && d[0] !== 1'b1; i++) begin
      repeat (8) @(posedge clk);
      rd(`BERT_A_STAT, d);
    end
    chk("locked status", 32'(d & 8'h0F), 32'h09);
    chk("sync loss pin", 32'(sync_loss), 32'h0);
    rd(`BERT_A_RXP0, d);
    for (int r = 0; r < 8; r++) begin
      if (8'({d, d} >> r) == 8'h3C) begin
        ok = 1'b1;
      end
    end
    chk("received pattern", 32'(ok), 32'h1);
    wr(`BERT_A_MASK, 8'h01);
    @(posedge clk);
    #1;
    chk("interrupt on lock", 32'({int_n_oe, int_n_out}), 32'h2);
    wr(`BERT_A_MASK, 8'h00);
    wr(`BERT_A_CTRL, 8'h0B);
    wr(`BERT_A_INJ, 8'h08);
    repeat (30) @(posedge tx_clk);
    wr(`BERT_A_CTRL, 8'h0B);
    rd32(`BERT_A_ERR0, v);
    chk("single error tally", v, 32'h1);
    rd32(`BERT_A_BIT0, v);
    chk("bit tally span", 32'(v >= 28 && v <= 33), 32'h1);
    rd(`BERT_A_STAT, d);
    chk("error seen set", 32'(d[4]), 32'h1);
    rd(`BERT_A_STAT, d);
    chk("error seen cleared", 32'(d[4]), 32'h0);
    wr(`BERT_A_INJ, 8'h01);
    repeat (100) @(posedge tx_clk);
    wr(`BERT_A_INJ, 8'h00);
    @(posedge clk);
    lc_pin <= 1'b1;
    repeat (6) @(posedge clk);
    lc_pin <= 1'b0;
    rd32(`BERT_A_ERR0, v);
    chk("rate 1 tally", 32'(v >= 9 && v <= 11), 32'h1);
    wr(`BERT_A_CTRL, 8'h07);
    rd(`BERT_A_STAT, d);
    chk("resync drops lock", 32'(d[0]), 32'h0);
    $display("test sync done");
  endtask
  task automatic t_test();
    chk("outputs enabled", 32'({tx_data_oe, sync_loss_oe}), 32'h3);
    @(posedge clk);
    test_mode <= 1'b1;
    repeat (6) @(posedge clk);
    chk("outputs released", 32'({tx_data_oe, sync_loss_oe, int_n_oe, bus_rdata_oe}),
      32'h0);
    $display("test release done");
  endtask
  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    rst_n = 1'b0;
    bus_req = '0;
    ld_pin = 1'b0;
    lc_pin = 1'b0;
    test_mode = 1'b0;
    run = 1'b0;
    n_mismatch = 0;
    comparisons = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    run <= 1'b1;
    t_regs();
    t_load(1'b0, 8'hA5);
    t_flags(8'hFF, 8'h02);
    t_flags(8'h00, 8'h04);
    t_load(1'b1, 8'h3C);
    t_sync();
    t_prbs();
    t_test();
    end_sim();
  end
  initial begin
    #5000000;
    n_mismatch++;
    end_sim();
  end
endmodule
`default_nettype wire

/* File: rtl/bert_params.svh */
// bert_params.svh: offsets, reset values and counts of the BER tester.
// Assumes: included by bare name from the package and the top module.
`ifndef BERT_PARAMS_SVH
`define BERT_PARAMS_SVH
// ****************************************
// register map (8-bit port, byte addresses)
// ****************************************
`define BERT_A_SEED0 8'h00
`define BERT_A_SEED3 8'h03
`define BERT_A_LEN 8'h04
`define BERT_A_TAP 8'h05
`define BERT_A_CTRL 8'h06
`define BERT_A_INJ 8'h07
`define BERT_A_STAT 8'h08
`define BERT_A_MASK 8'h09
`define BERT_A_ERR0 8'h0A
`define BERT_A_ERR3 8'h0D
`define BERT_A_BIT0 8'h0E
`define BERT_A_BIT3 8'h11
`define BERT_A_RXP0 8'h12
`define BERT_A_RXP3 8'h15
// ****************************************
// reset values
// ****************************************
`define BERT_RST_BYTE 8'h00
`define BERT_RST_LEN 5'h1F
`define BERT_RST_TAP 5'h00
// ****************************************
// counts
// ****************************************
`define BERT_SYNC_BASE 7'h22
`define BERT_RATE1 24'h00000A
`define BERT_RATE2 24'h000064
`define BERT_RATE3 24'h0003E8
`define BERT_RATE4 24'h002710
`define BERT_RATE5 24'h0186A0
`define BERT_RATE6 24'h0F4240
`define BERT_RATE7 24'h989680
`endif

/* File: rtl/bert_pkg.sv */
// bert_pkg: types shared by the BER tester and its bench.
// Assumes: bert_params.svh on the include path.
`include "bert_params.svh"
package bert_pkg;
  // register port request, one cycle per access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bert_req_t;
  // pattern control byte, bit 7 down to bit 0
  typedef struct packed {
    logic load;
    logic [2:0] spare;
    logic count_latch;
    logic resync;
    logic sync_en;
    logic repetitive;
  } bert_ctrl_t;
  // error insertion byte; rate 0 is off, k gives one error in 10^k bits
  typedef struct packed {
    logic [3:0] spare;
    logic single;
    logic [2:0] rate;
  } bert_inj_t;
  typedef enum logic [1:0] {
    BERT_HUNT = 2'b01,
    BERT_LOCK = 2'b10
  } bert_state_t;
endpackage

/* File: rtl/bert_top.sv */
// bert_top: transmit pattern generator, receive checker and counters of a BER tester.
// Assumes: all link pins are asynchronous to clk and much slower than it.
// How it works
// R1: rising load copies seed bytes into the generator and restarts it
// R2: pattern MSB leaves on tx data after the third transmit clock edge
// R3: load request is the load pin ORed with control bit 7
// R4: pseudorandom lock after 34 plus n error-free bits, n the length
// R5: received bits checked against the transmit polynomial feedback
// R6: repetitive mode matches any pattern repeating at the transmit length
// R7: while locked every mismatching bit increments the error counter
// R8: host confirms lock using all-ones, all-zeros flags and received pattern
// R9: control bits sync enable and resync steer the receive synchroniser
// R10: 32-bit error tally and bit tally readable by the host
// R11: host divides error tally by bit tally to get the rate
// R12: count latch, bit or pin, ends one integration period, starts next
// R13: injection register inserts single errors or rates 10^-1 to 10^-7
// R14: first feedback tap always at stage length minus one
// R15: second feedback tap is programmable to any stage
// R16: repetitive lengths 1 to 32 and polynomials up to 32 stages
// R17: test input high releases every output; low enables them
// R18: host writes every register before relying on operation
// R19: transmit and receive halves run independently on their own clocks
// R20: bus style strap selects strobe style; captured and shown in status (the code only shows it in status bit 3, no strobe logic uses it)
// R21: address taken from the address lines with each strobe
// R22: interrupt is active-low open drain for enabled status bits
// R23: receive logic advances on receive clock, generator on transmit clock
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`include "bert_params.svh"
`timescale 1ns/1ps
`default_nettype none
module bert_top #(
  parameter int PAT_W = 32,
  parameter int CNT_W = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire bert_pkg::bert_req_t bus_req,
  output logic [7:0] bus_rdata,
  output logic bus_rdata_oe,
  // link and control pins
  input wire logic transmit_bit_clock,
  input wire logic rx_clock,
  input wire logic rx_data,
  input wire logic transmit_load_strobe,
  input wire logic count_latch,
  input wire logic bus_style_strap,
  input wire logic test_mode,
  // outputs
  output logic tx_data,
  output logic tx_data_oe,
  output logic receive_sync_loss_out,
  output logic sync_loss_oe,
  output logic int_n_out,
  output logic int_n_oe
);
  import bert_pkg::*;
  // ****************************************
  // pin synchronisers
  // ****************************************
  localparam int NS = 7;
  logic [NS-1:0] pin_in, meta_r, sync_r, prev_r;
  assign pin_in = {test_mode, bus_style_strap, count_latch, transmit_load_strobe,
                   rx_data, rx_clock, transmit_bit_clock};
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end
  logic txe, rxe, rbit, test_s;
  assign txe = sync_r[0] & ~prev_r[0]; // [R19]
  assign rxe = sync_r[1] & ~prev_r[1]; // [R19] [R23]
  assign rbit = sync_r[2];
  assign test_s = sync_r[6];

  // ****************************************
  // registers
  // ****************************************
  logic [PAT_W-1:0] seed_r;
  logic [4:0] len_r, tap_r;
  bert_ctrl_t ctrl_r;
  bert_inj_t inj_r;
  logic [7:0] mask_r;
  logic err_seen_r, ld_stage_r;
  logic wr_seed, wr_ctrl, wr_inj;
  assign wr_seed = bus_req.wr && bus_req.addr <= `BERT_A_SEED3;
  assign wr_ctrl = bus_req.wr && bus_req.addr == `BERT_A_CTRL;
  assign wr_inj = bus_req.wr && bus_req.addr == `BERT_A_INJ;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      seed_r <= '0;
      len_r <= `BERT_RST_LEN;
      tap_r <= `BERT_RST_TAP;
      mask_r <= `BERT_RST_BYTE;
      ctrl_r <= bert_ctrl_t'(`BERT_RST_BYTE);
      inj_r <= bert_inj_t'(`BERT_RST_BYTE);
    end else begin
      // resync and count latch are one-shot; load stays as written
      ctrl_r.resync <= 1'b0;
      ctrl_r.count_latch <= 1'b0;
      if (wr_seed)
        seed_r[8*bus_req.addr[1:0] +: 8] <= bus_req.wdata; // [R21]
      if (bus_req.wr && bus_req.addr == `BERT_A_LEN)
        len_r <= bus_req.wdata[4:0]; // [R16]
      if (bus_req.wr && bus_req.addr == `BERT_A_TAP)
        tap_r <= bus_req.wdata[4:0]; // [R15]
      if (bus_req.wr && bus_req.addr == `BERT_A_MASK)
        mask_r <= bus_req.wdata;
      if (wr_ctrl)
        ctrl_r <= bert_ctrl_t'(bus_req.wdata); // [R9]
      if (wr_inj)
        inj_r <= bert_inj_t'(bus_req.wdata);
      else if (txe && !ld_stage_r)
        inj_r.single <= 1'b0; // [R13]
    end
  end

  // ****************************************
  // transmit generator
  // ****************************************
  logic ld_req, ld_prev_r, ld_edge, ld_pend_r;
  logic [PAT_W-1:0] gen_r;
  logic [23:0] rate_cnt_r, rate_mod;
  logic fb, flip;
  assign ld_req = sync_r[3] | ctrl_r.load; // [R3]
  assign ld_edge = ld_req & ~ld_prev_r; // [R1]
  assign fb = ctrl_r.repetitive ? gen_r[len_r] : gen_r[len_r] ^ gen_r[tap_r]; // [R14] [R15]
  always_comb begin
    case (inj_r.rate)
      3'h1: rate_mod = `BERT_RATE1;
      3'h2: rate_mod = `BERT_RATE2;
      3'h3: rate_mod = `BERT_RATE3;
      3'h4: rate_mod = `BERT_RATE4;
      3'h5: rate_mod = `BERT_RATE5;
      3'h6: rate_mod = `BERT_RATE6;
      3'h7: rate_mod = `BERT_RATE7;
      default: rate_mod = '0;
    endcase
  end
  assign flip = inj_r.single | (rate_mod != '0 && rate_cnt_r == rate_mod - 24'h000001); // [R13]
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ld_prev_r <= 1'b0;
      ld_pend_r <= 1'b0;
      ld_stage_r <= 1'b0;
      gen_r <= '0;
      tx_data <= 1'b0;
      rate_cnt_r <= '0;
    end else begin
      ld_prev_r <= ld_req;
      // a new load in the cycle the pending one is taken is kept
      ld_pend_r <= ld_edge | (ld_pend_r & ~txe); // [R1]
      if (txe) begin
        ld_stage_r <= ld_pend_r; // [R2]
        if (ld_stage_r) begin
          gen_r <= seed_r; // [R1]
          rate_cnt_r <= '0;
        end else begin
          gen_r <= {gen_r[PAT_W-2:0], fb}; // [R16]
          tx_data <= gen_r[len_r] ^ flip; // [R2] [R13]
          rate_cnt_r <= (rate_cnt_r >= rate_mod - 24'h000001) ? '0 : rate_cnt_r + 24'h000001;
        end
      end
    end
  end

  // ****************************************
  // receive checker
  // ****************************************
  bert_state_t state_r;
  logic [PAT_W-1:0] rsr_r;
  logic [6:0] good_r, need;
  logic exp_bit, err;
  logic cl_prev_r, cl_edge;
  logic [CNT_W-1:0] err_live_r, bit_live_r, err_tally_r, bit_tally_r;
  assign exp_bit = ctrl_r.repetitive ? rsr_r[len_r] // [R6]
                                     : rsr_r[len_r] ^ rsr_r[tap_r]; // [R5]
  assign err = rbit ^ exp_bit;
  assign need = `BERT_SYNC_BASE + {2'b00, len_r} + 7'h01; // [R4]
  assign cl_edge = (sync_r[4] & ~cl_prev_r) | ctrl_r.count_latch; // [R12]
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= BERT_HUNT;
      rsr_r <= '0;
      good_r <= '0;
    end else begin
      // once locked the reference runs free, so a line error is counted only once
      if (rxe)
        rsr_r <= {rsr_r[PAT_W-2:0], state_r == BERT_LOCK ? exp_bit : rbit}; // [R23] [R7]
      if (!ctrl_r.sync_en || ctrl_r.resync) begin
        state_r <= BERT_HUNT; // [R9]
        good_r <= '0;
      end else if (rxe) begin
        case (state_r)
          BERT_HUNT: begin
            good_r <= err ? '0 : good_r + 7'h01;
            if (!err && good_r + 7'h01 >= need)
              state_r <= BERT_LOCK; // [R4]
          end
          BERT_LOCK: good_r <= good_r;
          default: state_r <= BERT_HUNT;
        endcase
      end
    end
  end
  logic lock_bit;
  assign lock_bit = rxe && state_r == BERT_LOCK;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cl_prev_r <= 1'b0;
      err_live_r <= '0;
      bit_live_r <= '0;
      err_tally_r <= '0;
      bit_tally_r <= '0;
    end else begin
      cl_prev_r <= sync_r[4];
      if (cl_edge) begin
        err_tally_r <= err_live_r; // [R10] [R12]
        bit_tally_r <= bit_live_r;
        err_live_r <= {{(CNT_W-1){1'b0}}, lock_bit & err};
        bit_live_r <= {{(CNT_W-1){1'b0}}, lock_bit};
      end else if (lock_bit) begin
        bit_live_r <= bit_live_r + 1'b1;
        err_live_r <= err_live_r + {{(CNT_W-1){1'b0}}, err}; // [R7]
      end
    end
  end

  // ****************************************
  // status, read port and pins
  // ****************************************
  logic all_ones, all_zeros;
  logic [7:0] status, rd_val;
  assign all_ones = &rsr_r;
  assign all_zeros = ~|rsr_r;
  assign status = {3'h0, err_seen_r, sync_r[5], all_zeros, all_ones, state_r==BERT_LOCK}; // [R20]
  always_ff @(posedge clk) begin
    if (!rst_n)
      err_seen_r <= 1'b0;
    else if (lock_bit && err)
      err_seen_r <= 1'b1; // set wins over the read clear
    else if (bus_req.rd && bus_req.addr == `BERT_A_STAT)
      err_seen_r <= 1'b0;
  end
  always_comb begin
    rd_val = '0;
    if (bus_req.addr <= `BERT_A_SEED3)
      rd_val = seed_r[8*bus_req.addr[1:0] +: 8];
    else if (bus_req.addr == `BERT_A_LEN)
      rd_val = {3'h0, len_r};
    else if (bus_req.addr == `BERT_A_TAP)
      rd_val = {3'h0, tap_r};
    else if (bus_req.addr == `BERT_A_CTRL)
      rd_val = ctrl_r;
    else if (bus_req.addr == `BERT_A_INJ)
      rd_val = inj_r;
    else if (bus_req.addr == `BERT_A_STAT)
      rd_val = status;
    else if (bus_req.addr == `BERT_A_MASK)
      rd_val = mask_r;
    else if (bus_req.addr >= `BERT_A_ERR0 && bus_req.addr <= `BERT_A_ERR3)
      rd_val = err_tally_r[8*(2'(bus_req.addr - `BERT_A_ERR0)) +: 8];
    else if (bus_req.addr >= `BERT_A_BIT0 && bus_req.addr <= `BERT_A_BIT3)
      rd_val = bit_tally_r[8*(2'(bus_req.addr - `BERT_A_BIT0)) +: 8];
    else if (bus_req.addr >= `BERT_A_RXP0 && bus_req.addr <= `BERT_A_RXP3)
      rd_val = rsr_r[8*(2'(bus_req.addr - `BERT_A_RXP0)) +: 8];
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bus_rdata <= '0;
      bus_rdata_oe <= 1'b0;
      receive_sync_loss_out <= 1'b1;
      sync_loss_oe <= 1'b0;
      tx_data_oe <= 1'b0;
      int_n_out <= 1'b0;
      int_n_oe <= 1'b0;
    end else begin
      bus_rdata <= bus_req.rd ? rd_val : '0; // [R21]
      bus_rdata_oe <= bus_req.rd & ~test_s; // [R17]
      receive_sync_loss_out <= state_r != BERT_LOCK;
      sync_loss_oe <= ~test_s; // [R17]
      tx_data_oe <= ~test_s; // [R17]
      int_n_out <= 1'b0;
      int_n_oe <= |(status & mask_r) & ~test_s; // [R22]
    end
  end
  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_load_arm;
    ld_edge |=> ld_pend_r;
  endproperty
  a_load_arm: assert property (p_load_arm) else $error("load edge not armed"); // [R1]
  property p_or_load;
    $rose(ctrl_r.load) && !sync_r[3] && !ld_prev_r |=> ld_pend_r;
  endproperty
  a_or_load: assert property (p_or_load) else $error("control load bit ignored"); // [R3]
  property p_seed_copy;
    txe && ld_stage_r |=> gen_r == $past(seed_r);
  endproperty
  a_seed_copy: assert property (p_seed_copy) else $error("seed not copied"); // [R2]
  property p_lock_count;
    $rose(state_r == BERT_LOCK) |-> $past(good_r) + 7'h01 >= $past(need);
  endproperty
  a_lock_count: assert property (p_lock_count) else $error("lock too early"); // [R4]
  property p_err_count;
    lock_bit && err && !cl_edge |=> err_live_r == $past(err_live_r) + 1'b1;
  endproperty
  a_err_count: assert property (p_err_count) else $error("error not counted"); // [R7]
  property p_sync_off;
    !ctrl_r.sync_en |=> state_r == BERT_HUNT;
  endproperty
  a_sync_off: assert property (p_sync_off) else $error("locked while disabled"); // [R9]
  property p_latch;
    cl_edge |=> bit_tally_r == $past(bit_live_r) && err_tally_r == $past(err_live_r);
  endproperty
  a_latch: assert property (p_latch) else $error("tallies not latched"); // [R12]
  property p_test_off;
    test_s |=> !tx_data_oe && !sync_loss_oe && !int_n_oe && !bus_rdata_oe;
  endproperty
  a_test_off: assert property (p_test_off) else $error("output driven in test"); // [R17]
  property p_single;
    inj_r.single && txe && !ld_stage_r && !wr_inj |=> tx_data != $past(gen_r[len_r]);
  endproperty
  a_single: assert property (p_single) else $error("single error not inserted"); // [R13]
  c_lock: cover property ($rose(state_r == BERT_LOCK));
  c_err: cover property (lock_bit && err);
  c_load: cover property (txe && ld_stage_r);
  c_latch: cover property (cl_edge && bit_live_r != '0);
endmodule
`default_nettype wire
